// ---- rtl/pcb_balance_ctrl.sv ----
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "pcb_map.svh"

module pcb_balance_ctrl
    import pcb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pcb_pkg::pcb_meas_s meas,
    input wire logic [pcb_pkg::NGPI-1:0] gpi_pin,
    output logic [pcb_pkg::NCELL-1:0] bleed_en,
    output logic meas_start,
    output logic breaker_fault,
    output logic contactor_open,
    output logic irq
);
    import pcb_pkg::*;

    // ==========================================================
    // Register decode
    // ==========================================================
    function automatic logic is_reg(input logic [31:0] a, input logic [7:0] off);
        is_reg = (a[31:8] == 24'h0) && (a[7:0] == off);
    endfunction
    function automatic logic mapped(input logic [31:0] a);
        mapped = (a[31:8] == 24'h0) && (a[1:0] == 2'h0) && (a[7:2] <= 6'h0B);
    endfunction
    // ==========================================================
    // Register file and bus slave
    // ==========================================================
    logic [31:0] ctrl_q, ctrl_d;
    logic [15:0] min_v_q, min_v_d, delta_v_q, delta_v_d, scan_q, scan_d, settle_q, settle_d;
    logic signed [15:0] max_t_q, max_t_d;
    logic signed [31:0] min_i_q, min_i_d, max_i_q, max_i_d;
    logic [1:0] ist_q, ist_d, imask_q, imask_d;
    logic [31:0] awaddr_q, awaddr_d, wdata_q, wdata_d;
    logic aw_q, aw_d, w_q, w_d, bvalid_q, bvalid_d, bresp_err_q, bresp_err_d;
    logic rvalid_q, rvalid_d, rresp_err_q, rresp_err_d;
    logic [31:0] rdata_q, rdata_d;
    logic [3:0] wstrb_q, wstrb_d;
    logic irq_q, irq_d;
    logic eval_pulse, fault_rise;
    logic [NCELL-1:0] bleed_q, bleed_d;
    logic brk_q, brk_d;
    pcb_phase_e phase_q, phase_d;
    function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                          input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            merge[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
        end
    endfunction
    function automatic logic [31:0] read_reg(input logic [31:0] a);
        read_reg = 32'h0;
        if (is_reg(a, `PCB_REG_CTRL)) read_reg = ctrl_q;
        if (is_reg(a, `PCB_REG_MIN_V)) read_reg = {16'h0, min_v_q};
        if (is_reg(a, `PCB_REG_DELTA_V)) read_reg = {16'h0, delta_v_q};
        if (is_reg(a, `PCB_REG_MAX_T)) read_reg = {{16{max_t_q[15]}}, max_t_q};
        if (is_reg(a, `PCB_REG_MIN_I)) read_reg = min_i_q;
        if (is_reg(a, `PCB_REG_MAX_I)) read_reg = max_i_q;
        if (is_reg(a, `PCB_REG_SCAN)) read_reg = {16'h0, scan_q};
        if (is_reg(a, `PCB_REG_SETTLE)) read_reg = {16'h0, settle_q};
        if (is_reg(a, `PCB_REG_BAL)) read_reg = {{(32-NCELL){1'b0}}, bleed_q};
        if (is_reg(a, `PCB_REG_IRQ_STAT)) read_reg = {30'h0, ist_q};
        if (is_reg(a, `PCB_REG_IRQ_MASK)) read_reg = {30'h0, imask_q};
        if (is_reg(a, `PCB_REG_STATUS)) read_reg = {28'h0, phase_q, brk_q, contactor_open};
    endfunction
    always_comb begin
        logic do_wr;
        logic [31:0] wv;
        do_wr = 1'b0;
        wv = 32'h0;
        aw_d = aw_q;
        w_d = w_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb_d = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_err_d = bresp_err_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_err_d = rresp_err_q;
        ctrl_d = ctrl_q;
        min_v_d = min_v_q;
        delta_v_d = delta_v_q;
        max_t_d = max_t_q;
        min_i_d = min_i_q;
        max_i_d = max_i_q;
        scan_d = scan_q;
        settle_d = settle_q;
        imask_d = imask_q;
        ist_d = ist_q;
        if (s_axi_awvalid && !aw_q && !bvalid_q) begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_q && !bvalid_q) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (aw_q && w_q) begin
            do_wr = 1'b1;
            aw_d = 1'b0;
            w_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_err_d = !mapped(awaddr_q);
        end
        if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (do_wr) begin
            if (is_reg(awaddr_q, `PCB_REG_CTRL)) ctrl_d = merge(ctrl_q, wdata_q, wstrb_q);
            if (is_reg(awaddr_q, `PCB_REG_MIN_V)) begin
                wv = merge({16'h0, min_v_q}, wdata_q, wstrb_q);
                min_v_d = (wv[15:0] < `PCB_FLOOR_MV) ? `PCB_FLOOR_MV : wv[15:0];
            end
            if (is_reg(awaddr_q, `PCB_REG_DELTA_V)) begin
                wv = merge({16'h0, delta_v_q}, wdata_q, wstrb_q);
                delta_v_d = wv[15:0];
            end
            if (is_reg(awaddr_q, `PCB_REG_MAX_T)) begin
                wv = merge({16'h0, max_t_q}, wdata_q, wstrb_q);
                max_t_d = wv[15:0];
            end
            if (is_reg(awaddr_q, `PCB_REG_MIN_I)) min_i_d = merge(min_i_q, wdata_q, wstrb_q);
            if (is_reg(awaddr_q, `PCB_REG_MAX_I)) max_i_d = merge(max_i_q, wdata_q, wstrb_q);
            if (is_reg(awaddr_q, `PCB_REG_SCAN)) begin
                wv = merge({16'h0, scan_q}, wdata_q, wstrb_q);
                scan_d = wv[15:0];
            end
            if (is_reg(awaddr_q, `PCB_REG_SETTLE)) begin
                wv = merge({16'h0, settle_q}, wdata_q, wstrb_q);
                settle_d = wv[15:0];
            end
            if (is_reg(awaddr_q, `PCB_REG_IRQ_MASK)) imask_d = wdata_q[1:0] & {2{wstrb_q[0]}};
            if (is_reg(awaddr_q, `PCB_REG_IRQ_STAT)) ist_d = ist_q & ~(wdata_q[1:0] & {2{wstrb_q[0]}});
        end
        // Set wins over clear
        if (eval_pulse) ist_d[`PCB_IRQ_EVAL] = 1'b1;
        if (fault_rise) ist_d[`PCB_IRQ_FAULT] = 1'b1;
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rdata_d = read_reg(s_axi_araddr);
            rresp_err_d = !mapped(s_axi_araddr);
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        irq_d = |(ist_d & imask_d);
    end

    // ==========================================================
    // Scan sequencer and balancing decision
    // ==========================================================
    logic [31:0] cnt_q, cnt_d;
    logic [31:0] scan_cyc, settle_cyc;
    logic [NGPI-1:0] gpi_s1_q, gpi_s2_q;
    logic meas_q, meas_d, copen_q, copen_d;
    logic [15:0] vmin;
    logic cur_ok, temp_ok;
    logic [15:0] settle_eff;

    // settle clamped to legal range if software misconfigures
    always_comb begin
        settle_eff = (settle_q < `PCB_SETTLE_MIN_MS) ? `PCB_SETTLE_MIN_MS : settle_q;
        if (settle_eff >= scan_q) settle_eff = scan_q - 16'd1;
        scan_cyc = 32'(scan_q) * 32'(`PCB_CYC_PER_MS);
        settle_cyc = 32'(settle_eff) * 32'(`PCB_CYC_PER_MS);
    end

    always_comb begin
        vmin = 16'hFFFF;
        for (int i = 0; i < NCELL; i++) begin
            if (meas.cell_mv[i] < vmin) vmin = meas.cell_mv[i];
        end
        temp_ok = !(meas.temp_c > max_t_q);
        cur_ok = !(meas.stack_ma < min_i_q) && !(meas.stack_ma > max_i_q);
    end
    always_comb begin
        phase_d = phase_q;
        cnt_d = cnt_q + 32'd1;
        bleed_d = bleed_q;
        meas_d = 1'b0;
        eval_pulse = 1'b0;
        case (phase_q)
            PCB_BALANCE: begin
                if (cnt_q + settle_cyc + 32'd1 >= scan_cyc) begin
                    phase_d = PCB_SETTLE;
                    cnt_d = 32'd0;
                    bleed_d = '0;
                end
            end
            PCB_SETTLE: begin
                bleed_d = '0;
                if (cnt_q + 32'd1 >= settle_cyc) begin
                    phase_d = PCB_MEASURE;
                    meas_d = 1'b1;
                end
            end
            PCB_MEASURE: begin
                bleed_d = '0;
                if (meas.valid) begin
                    eval_pulse = 1'b1;
                    phase_d = PCB_BALANCE;
                    cnt_d = 32'd0;
                    for (int i = 0; i < NCELL; i++) begin
                        bleed_d[i] = ctrl_q[`PCB_CTRL_BAL_EN] && temp_ok && cur_ok
                            && meas.cell_mv[i] >= min_v_q
                            && (meas.cell_mv[i] - vmin) >= delta_v_q;
                    end
                end
            end
            default: phase_d = PCB_BALANCE;
        endcase
        if (!ctrl_q[`PCB_CTRL_BAL_EN]) bleed_d = '0;
    end

    // Breaker path
    always_comb begin
        logic [1:0] sel;
        sel = ctrl_q[`PCB_CTRL_GPI_LSB +: 2];
        brk_d = ctrl_q[`PCB_CTRL_BRK_EN] && ctrl_q[`PCB_CTRL_FWD_EN] && gpi_s2_q[sel];
        copen_d = brk_d;
        fault_rise = brk_d && !brk_q;
    end

    always_ff @(posedge clk) begin
        gpi_s1_q <= gpi_pin;
        gpi_s2_q <= gpi_s1_q;
        if (srst) begin
            ctrl_q <= 32'h0;
            min_v_q <= `PCB_RST_MIN_V;
            delta_v_q <= `PCB_RST_DELTA_V;
            max_t_q <= `PCB_RST_MAX_T;
            min_i_q <= `PCB_RST_MIN_I;
            max_i_q <= `PCB_RST_MAX_I;
            scan_q <= `PCB_RST_SCAN_MS;
            settle_q <= `PCB_RST_SETTLE_MS;
            ist_q <= 2'h0;
            imask_q <= 2'h0;
            aw_q <= 1'b0;
            w_q <= 1'b0;
            awaddr_q <= 32'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            bvalid_q <= 1'b0;
            bresp_err_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= 32'h0;
            rresp_err_q <= 1'b0;
            irq_q <= 1'b0;
            phase_q <= PCB_BALANCE;
            cnt_q <= 32'h0;
            bleed_q <= '0;
            meas_q <= 1'b0;
            brk_q <= 1'b0;
            copen_q <= 1'b0;
        end else begin
            ctrl_q <= ctrl_d;
            min_v_q <= min_v_d;
            delta_v_q <= delta_v_d;
            max_t_q <= max_t_d;
            min_i_q <= min_i_d;
            max_i_q <= max_i_d;
            scan_q <= scan_d;
            settle_q <= settle_d;
            ist_q <= ist_d;
            imask_q <= imask_d;
            aw_q <= aw_d;
            w_q <= w_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb_q <= wstrb_d;
            bvalid_q <= bvalid_d;
            bresp_err_q <= bresp_err_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_err_q <= rresp_err_d;
            irq_q <= irq_d;
            phase_q <= phase_d;
            cnt_q <= cnt_d;
            bleed_q <= bleed_d;
            meas_q <= meas_d;
            brk_q <= brk_d;
            copen_q <= copen_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    assign s_axi_awready = !aw_q && !bvalid_q;
    assign s_axi_wready = !w_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_err_q ? 2'h2 : 2'h0;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_err_q ? 2'h2 : 2'h0;
    assign bleed_en = bleed_q;
    assign meas_start = meas_q;
    assign breaker_fault = brk_q;
    assign contactor_open = copen_q;
    assign irq = irq_q;
endmodule
`default_nettype wire

// ---- rtl/pcb_map.svh ----
`ifndef PCB_MAP_SVH
`define PCB_MAP_SVH

// Register byte offsets
`define PCB_REG_CTRL       8'h00
`define PCB_REG_MIN_V      8'h04
`define PCB_REG_DELTA_V    8'h08
`define PCB_REG_MAX_T      8'h0C
`define PCB_REG_MIN_I      8'h10
`define PCB_REG_MAX_I      8'h14
`define PCB_REG_SCAN       8'h18
`define PCB_REG_SETTLE     8'h1C
`define PCB_REG_BAL        8'h20
`define PCB_REG_IRQ_STAT   8'h24
`define PCB_REG_IRQ_MASK   8'h28
`define PCB_REG_STATUS     8'h2C

// Control field positions
`define PCB_CTRL_BAL_EN    0
`define PCB_CTRL_BRK_EN    1
`define PCB_CTRL_FWD_EN    2
`define PCB_CTRL_GPI_LSB   4

// Interrupt status bit positions
`define PCB_IRQ_EVAL       0
`define PCB_IRQ_FAULT      1

// Reset values
`define PCB_RST_MIN_V      16'd1100
`define PCB_RST_DELTA_V    16'd10
`define PCB_RST_MAX_T      16'sd45
`define PCB_RST_MIN_I      32'sh0
`define PCB_RST_MAX_I      32'sh0
`define PCB_RST_SCAN_MS    16'd200
`define PCB_RST_SETTLE_MS  16'd50

// Timing and limits
`define PCB_CLK_HZ         25000000
`define PCB_MS_NS          1000000
`define PCB_CLK_NS         40
`define PCB_CYC_PER_MS     (`PCB_MS_NS / `PCB_CLK_NS)
`define PCB_FLOOR_MV       16'd1100
`define PCB_SETTLE_MIN_MS  16'd50

`endif

// ---- rtl/pcb_pkg.sv ----
package pcb_pkg;
    localparam int NCELL = 16;
    localparam int NGPI = 4;

    typedef logic [15:0] pcb_mv_t;

    typedef struct packed {
        logic [NCELL-1:0][15:0] cell_mv;
        logic signed [15:0] temp_c;
        logic signed [31:0] stack_ma;
        logic valid;
    } pcb_meas_s;

    typedef enum logic [1:0] {
        PCB_BALANCE,
        PCB_SETTLE,
        PCB_MEASURE
    } pcb_phase_e;
endpackage

// ---- bench/pcb_balance_ctrl_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Port checks
module pcb_balance_ctrl_assertions
    import pcb_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic s_axi_awready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire pcb_pkg::pcb_meas_s meas,
    input wire logic [pcb_pkg::NGPI-1:0] gpi_pin,
    input wire logic [pcb_pkg::NCELL-1:0] bleed_en,
    input wire logic meas_start,
    input wire logic breaker_fault,
    input wire logic contactor_open
);
    localparam int MAX_T = 45;
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    logic [NCELL-1:0] low_q, low_d;
    // Cells measured under the floor
    always_comb begin
        low_d = low_q;
        if (meas.valid) begin
            for (int i = 0; i < NCELL; i++) low_d[i] = meas.cell_mv[i] < 16'h044C;
        end
    end
    always_ff @(posedge clk) begin
        low_q <= srst ? '0 : low_d;
    end
    a_floor_kept: assert property ((bleed_en & low_q) == '0)
        else $error("bleed on a cell under the floor");
    a_settle_off: assert property (meas_start |-> bleed_en == '0 && $past(bleed_en) == '0)
        else $error("bleed on at measurement start");
    a_bleed_held: assert property ((bleed_en & ~$past(bleed_en)) != '0 |-> $past(meas.valid))
        else $error("bleed rose without fresh measurement");
    a_hot_off: assert property ($past(meas.valid) && $past(meas.temp_c) > MAX_T |-> bleed_en == '0)
        else $error("bleed while over temperature");
    // Current window kept at its reset value of zero to zero
    a_curr_off: assert property ($past(meas.valid) && $past(meas.stack_ma) != 0 |-> bleed_en == '0)
        else $error("bleed outside current window");
    a_trip_opens: assert property ($rose(breaker_fault) |-> ##[0:1] contactor_open)
        else $error("contactors not opened on fault");
    a_trip_source: assert property ($rose(breaker_fault) |-> $past(gpi_pin, 3) != '0)
        else $error("breaker fault without input");
    a_start_pulse: assert property (meas_start |=> !meas_start)
        else $error("measure request longer than one cycle");
    a_resp_held: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped");
    a_read_held: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read response dropped");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
        else $error("write address taken during response");
    c_eval: cover property (meas.valid ##1 bleed_en != '0);
    c_trip: cover property ($rose(breaker_fault));
    c_start: cover property (meas_start);
endmodule
bind pcb_balance_ctrl pcb_balance_ctrl_assertions i_chk (.clk(clk), .srst(srst),
    .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .meas(meas), .gpi_pin(gpi_pin),
    .bleed_en(bleed_en), .meas_start(meas_start), .breaker_fault(breaker_fault),
    .contactor_open(contactor_open));
`default_nettype wire

// ---- bench/pcb_cell_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ==========
// Cell stack with scan front end
module pcb_cell_model
    import pcb_pkg::*;
#(
    parameter int LAT = 3
)(
    input wire logic clk,
    input wire logic srst,
    input wire logic meas_start,
    input wire logic [pcb_pkg::NCELL-1:0][15:0] mv,
    input wire logic signed [15:0] temp,
    input wire logic signed [31:0] ma,
    output var pcb_pkg::pcb_meas_s meas
);
    int cnt;
    always_ff @(posedge clk) begin
        if (srst) cnt <= 0;
        else if (meas_start) cnt <= LAT;
        else if (cnt > 0) cnt <= cnt - 1;
    end
    // Outside the valid pulse the data lines carry no stale values
    always_comb begin
        meas.valid = cnt == 1;
        meas.cell_mv = meas.valid ? mv : ~mv;
        meas.temp_c = meas.valid ? temp : ~temp;
        meas.stack_ma = meas.valid ? ma : ~ma;
    end
endmodule
`default_nettype wire

// ---- bench/pcb_balance_ctrl_tb.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "pcb_map.svh"
module pcb_balance_ctrl_tb;
    import pcb_pkg::*;
    logic clk, srst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    pcb_meas_s meas;
    logic [NCELL-1:0][15:0] mv;
    logic signed [15:0] temp;
    logic signed [31:0] ma;
    logic [NGPI-1:0] gpi_pin;
    logic [NCELL-1:0] bleed_en;
    logic meas_start, breaker_fault, contactor_open, irq;
    int num_errors, samples_checked, z;
    int tt[5] = '{46, 45, 45, 45, 45};
    int ti[5] = '{0, 1, -1, 0, 0};
    int td[5] = '{10, 10, 10, 10, 0};
    logic [15:0] te[5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0012, 16'h001E};
    pcb_balance_ctrl i_pcb_balance_ctrl (.clk, .srst, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .meas, .gpi_pin, .bleed_en,
        .meas_start, .breaker_fault, .contactor_open, .irq);
    pcb_cell_model i_pcb_cell_model (.clk, .srst, .meas_start, .mv, .temp, .ma, .meas);
    // ==========
    // Check and bus tasks
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, b;
        s_axi_awaddr <= {24'h0, a};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge clk);
            ah = s_axi_awvalid && s_axi_awready;
            wh = s_axi_wvalid && s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge clk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_bready <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, b;
        s_axi_araddr <= {24'h0, a};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge clk);
            ah = s_axi_arvalid && s_axi_arready;
            b = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge clk);
            if (ah) s_axi_arvalid <= 1'b0;
        end while (b !== 1'b1);
        s_axi_rready <= 1'b0;
        @(posedge clk);
    endtask
    // Counts idle-bleed cycles that lead into a fresh measurement
    task automatic wait_eval(output int n);
        n = 0;
        do begin
            @(negedge clk);
            n = (bleed_en === '0) ? n + 1 : 0;
        end while (meas.valid !== 1'b1);
        @(negedge clk);
    endtask
    task automatic conclude;
        if (num_errors == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========
    // Tests
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (320000) @(posedge clk);
        num_errors++;
        conclude();
    end
    initial begin
        {srst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
        {s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
        s_axi_wstrb = 4'hF;
        for (int i = 0; i < NCELL; i++) mv[i] = 16'h044B;
        mv[1] = 16'h0455;
        mv[2] = 16'h0454;
        mv[3] = 16'h044C;
        mv[4] = 16'h07D0;
        temp = 16'sd45;
        ma = 0;
        gpi_pin = 4'h0;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        wr(`PCB_REG_SCAN, 32'h2, rs);
        wr(`PCB_REG_SETTLE, 32'h1, rs);
        wr(8'h30, 32'h1, rs);
        chk(rs, 2'h2);
        rdr(8'h30, rd, rs);
        chk(rs, 2'h2);
        chk(rd, 32'h0);
        wr(`PCB_REG_MIN_V, 32'h10, rs);
        rdr(`PCB_REG_MIN_V, rd, rs);
        chk(rd, 32'h0000044C);
        wr(`PCB_REG_IRQ_MASK, 32'h2, rs);
        gpi_pin <= 4'h4;
        wr(`PCB_REG_CTRL, 32'h23, rs);
        repeat (5) @(posedge clk);
        chk(breaker_fault, 1'b0);
        wr(`PCB_REG_CTRL, 32'h17, rs);
        repeat (5) @(posedge clk);
        chk(breaker_fault, 1'b0);
        wr(`PCB_REG_CTRL, 32'h27, rs);
        repeat (5) @(posedge clk);
        chk(breaker_fault, 1'b1);
        chk(contactor_open, 1'b1);
        chk(irq, 1'b1);
        rdr(`PCB_REG_IRQ_STAT, rd, rs);
        chk(rd & 32'h2, 32'h2);
        wr(`PCB_REG_IRQ_STAT, 32'h2, rs);
        repeat (2) @(posedge clk);
        chk(irq, 1'b0);
        gpi_pin <= 4'h0;
        wr(`PCB_REG_CTRL, 32'h1, rs);
        for (int e = 0; e < 5; e++) begin
            temp <= 16'(tt[e]);
            ma <= ti[e];
            wr(`PCB_REG_DELTA_V, 32'(td[e]), rs);
            wait_eval(z);
            chk(bleed_en, te[e]);
            if (e == 4) chk(z >= 25000 && z <= 25010, 1'b1);
            @(posedge clk);
            rdr(`PCB_REG_BAL, rd, rs);
            chk(rd, te[e]);
        end
        wr(`PCB_REG_CTRL, 32'h0, rs);
        repeat (2) @(negedge clk);
        chk(bleed_en, 16'h0000);
        conclude();
    end
endmodule
`default_nettype wire
